// ===== core/exec_cfg.svh
`ifndef EXEC_CFG_SVH
`define EXEC_CFG_SVH

// ****************************************
// Register offsets and reset values
// ****************************************
`define OFS_JEXT 4'h0
`define OFS_STAT 4'h1
`define OFS_PROD_LO 4'h2
`define OFS_PROD_HI 4'h3
`define JEXT_RST 8'h00

// ****************************************
// Field positions
// ****************************************
`define FLAG_C 0
`define FLAG_Z 1
`define FLAG_N 2
`define FLAG_V 3
`define FLAG_H 5
`define FLAG_T 6
`define STAT_BUSY 0
`define STAT_TAKEN 1
`define STAT_MUL 2

// ****************************************
// Cycle counts
// ****************************************
`define MUL_CYC 3'h2
`define JMP_CYC 3'h2
`define CALL_CYC 3'h4
`define CMP_CYC 3'h1
`define BR_NT_CYC 3'h1
`define BR_T_CYC 3'h2
`define SKIP_NT_CYC 3'h1
`define SKIP_ONE_CYC 3'h2
`define SKIP_TWO_CYC 3'h3

// ****************************************
// Program counter steps
// ****************************************
`define PC_STEP 8'h01
`define PC_SKIP_ONE 8'h02
`define PC_SKIP_TWO 8'h03

`endif

// ===== core/exec_pkg.sv
package exec_pkg;
    typedef enum logic [4:0] {
        no_operation,
        signed_multiply,
        signed_by_unsigned_multiply,
        fractional_unsigned_multiply,
        fractional_signed_multiply,
        fractional_mixed_multiply,
        pointer_jump,
        extended_pointer_jump,
        pointer_call,
        extended_pointer_call,
        compare_skip_equal,
        compare_immediate,
        skip_reg_bit_clear,
        skip_reg_bit_set,
        skip_io_bit_clear,
        skip_io_bit_set,
        branch_flag_set,
        branch_flag_clear,
        branch_greater_equal,
        branch_less_than,
        branch_half_carry_set,
        branch_half_carry_clear,
        branch_transfer_bit_set,
        branch_transfer_bit_clear,
        branch_same_or_higher,
        branch_carry_clear,
        branch_lower,
        branch_carry_set,
        branch_overflow_set,
        branch_overflow_clear
    } op_e;
endpackage

// ===== core/exec_unit.sv
// The register addresses and the strobed register port were chosen for this implementation.
`include "exec_cfg.svh"

// Notes on behaviour
// - Signed and signed-by-unsigned multiply write 16-bit product, Z and C, 2 cycles.
// - Fractional multiplies shift the product left one before writing; Z, C, 2 cycles.
// - Pointer jump loads PC from Z, no flags, 2 cycles.
// - Extended pointer jump loads PC from extension register above Z, 2 cycles.
// - Pointer call goes to Z, no flags, 4 cycles.
// - Extended pointer call goes to extension register above Z, 4 cycles.
// - Compare-skip-equal skips next instruction when operands match; 1, 2 or 3 cycles.
// - Compare immediate subtracts constant, sets Z N V C H, stores nothing, 1 cycle.
// - Register bit skips test one operand bit, clear or set variant; 1-3 cycles.
// - I/O bit skips test one I/O register bit, clear or set; 1-3 cycles.
// - Generic flag branches add offset plus one when selected flag matches; 1/2 cycles.
// - Greater-or-equal branch taken when N xor V is zero; 1/2 cycles.
// - Half-carry branches follow H set or clear; 1/2 cycles.
// - Transfer-bit branches follow T set or clear; 1/2 cycles.
// - Same-or-higher and carry-clear take on C=0; lower and carry-set on C=1.
// - Overflow branches take on V=1 or V=0; 1/2 cycles.
module exec_unit import exec_pkg::*; #(
    parameter int PC_W = 22
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic start,
    input wire op_e op,
    input wire logic [7:0] rd_val,
    input wire logic [7:0] src_val,
    input wire logic [7:0] imm,
    input wire logic [2:0] bit_sel,
    input wire logic [7:0] io_val,
    input wire logic [2:0] flag_sel,
    input wire logic [6:0] offset,
    input wire logic [15:0] z_ptr,
    input wire logic [PC_W-1:0] pc,
    input wire logic [7:0] status_register,
    input wire logic next_two_word,
    output logic ready,
    output logic done,
    output logic pc_load,
    output logic [PC_W-1:0] pc_value,
    output logic prod_we,
    output logic [15:0] prod_value,
    output logic [7:0] flag_we,
    output logic [7:0] flag_value,
    output logic ret_push,
    output logic [PC_W-1:0] ret_addr,
    input wire logic [3:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [7:0] bus_rdata
);
    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [2:0] cnt;
        logic done;
        logic pc_upd;
        logic is_mul;
        logic taken;
        logic push;
        logic [PC_W-1:0] target;
        logic [PC_W-1:0] ret;
        logic [15:0] prod;
        logic [7:0] fmask;
        logic [7:0] fval;
        logic [7:0] jump_ext;
        logic [7:0] rdata;
    } state_s;

    localparam state_s ST_RST = '{jump_ext: `JEXT_RST, default: '0};

    state_s st;
    state_s next_st;

    function automatic logic [PC_W-1:0] pc_add(input logic [PC_W-1:0] base, input logic [7:0] delta);
        pc_add = base + {{(PC_W-8){delta[7]}}, delta};
    endfunction

    // ****************************************
    // Operand helpers
    // ****************************************
    logic accept;
    logic a_signed;
    logic b_signed;
    logic frac;
    logic [15:0] mul_prod;
    logic mul_carry;
    logic mul_zero;
    logic [7:0] diff;
    logic [7:0] kofs;
    logic cond;
    logic n_xor_v;

    assign accept = start && (st.cnt == 3'h0);
    assign a_signed = (op == signed_multiply) || (op == signed_by_unsigned_multiply)
        || (op == fractional_signed_multiply) || (op == fractional_mixed_multiply);
    assign b_signed = (op == signed_multiply) || (op == fractional_signed_multiply);
    assign frac = (op == fractional_unsigned_multiply) || (op == fractional_signed_multiply)
        || (op == fractional_mixed_multiply);
    assign diff = rd_val - imm;
    // Sign-extended offset plus one; 63 + 1 still fits in eight signed bits
    assign kofs = {offset[6], offset} + `PC_STEP;
    assign n_xor_v = status_register[`FLAG_N] ^ status_register[`FLAG_V];

    product_unit mul (
        .a(rd_val),
        .b(src_val),
        .a_signed(a_signed),
        .b_signed(b_signed),
        .frac(frac),
        .product(mul_prod),
        .carry(mul_carry),
        .zero(mul_zero)
    );

    // ****************************************
    // Branch condition
    // ****************************************
    always_comb begin
        case (op)
            branch_flag_set: cond = status_register[flag_sel];
            branch_flag_clear: cond = !status_register[flag_sel];
            branch_greater_equal: cond = !n_xor_v;
            branch_less_than: cond = n_xor_v;
            branch_half_carry_set: cond = status_register[`FLAG_H];
            branch_half_carry_clear: cond = !status_register[`FLAG_H];
            branch_transfer_bit_set: cond = status_register[`FLAG_T];
            branch_transfer_bit_clear: cond = !status_register[`FLAG_T];
            branch_same_or_higher, branch_carry_clear: cond = !status_register[`FLAG_C];
            branch_lower, branch_carry_set: cond = status_register[`FLAG_C];
            branch_overflow_set: cond = status_register[`FLAG_V];
            branch_overflow_clear: cond = !status_register[`FLAG_V];
            default: cond = 1'b0;
        endcase
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        logic skip_op;
        logic skip;
        skip_op = 1'b0;
        skip = 1'b0;
        next_st = st;
        next_st.done = 1'b0;
        next_st.push = 1'b0;
        next_st.rdata = 8'h00;
        if (st.cnt != 3'h0) begin
            next_st.cnt = st.cnt - 3'h1;
            next_st.done = (st.cnt == 3'h1);
        end
        if (accept) begin
            next_st.pc_upd = 1'b1;
            next_st.is_mul = 1'b0;
            next_st.taken = 1'b0;
            next_st.fmask = 8'h00;
            next_st.fval = 8'h00;
            case (op)
                signed_multiply, signed_by_unsigned_multiply, fractional_unsigned_multiply,
                fractional_signed_multiply, fractional_mixed_multiply: begin
                    next_st.pc_upd = 1'b0;
                    next_st.is_mul = 1'b1;
                    next_st.prod = mul_prod;
                    next_st.fmask[`FLAG_Z] = 1'b1;
                    next_st.fmask[`FLAG_C] = 1'b1;
                    next_st.fval[`FLAG_Z] = mul_zero;
                    next_st.fval[`FLAG_C] = mul_carry;
                    next_st.cnt = `MUL_CYC;
                end
                pointer_jump: begin
                    next_st.target = PC_W'(z_ptr);
                    next_st.cnt = `JMP_CYC;
                end
                extended_pointer_jump: begin
                    next_st.target = PC_W'({st.jump_ext, z_ptr});
                    next_st.cnt = `JMP_CYC;
                end
                pointer_call: begin
                    next_st.push = 1'b1;
                    next_st.ret = pc_add(pc, `PC_STEP);
                    next_st.target = PC_W'(z_ptr);
                    next_st.cnt = `CALL_CYC;
                end
                extended_pointer_call: begin
                    next_st.push = 1'b1;
                    next_st.ret = pc_add(pc, `PC_STEP);
                    next_st.target = PC_W'({st.jump_ext, z_ptr});
                    next_st.cnt = `CALL_CYC;
                end
                compare_immediate: begin
                    next_st.pc_upd = 1'b0;
                    next_st.fmask[`FLAG_Z] = 1'b1;
                    next_st.fmask[`FLAG_N] = 1'b1;
                    next_st.fmask[`FLAG_V] = 1'b1;
                    next_st.fmask[`FLAG_C] = 1'b1;
                    next_st.fmask[`FLAG_H] = 1'b1;
                    next_st.fval[`FLAG_Z] = (diff == 8'h00);
                    next_st.fval[`FLAG_N] = diff[7];
                    next_st.fval[`FLAG_V] = (rd_val[7] & ~imm[7] & ~diff[7])
                        | (~rd_val[7] & imm[7] & diff[7]);
                    next_st.fval[`FLAG_C] = (~rd_val[7] & imm[7]) | (imm[7] & diff[7])
                        | (diff[7] & ~rd_val[7]);
                    next_st.fval[`FLAG_H] = (~rd_val[3] & imm[3]) | (imm[3] & diff[3])
                        | (diff[3] & ~rd_val[3]);
                    next_st.cnt = `CMP_CYC;
                end
                compare_skip_equal: begin
                    skip_op = 1'b1;
                    skip = (rd_val == src_val);
                end
                skip_reg_bit_clear: begin
                    skip_op = 1'b1;
                    skip = !src_val[bit_sel];
                end
                skip_reg_bit_set: begin
                    skip_op = 1'b1;
                    skip = src_val[bit_sel];
                end
                skip_io_bit_clear: begin
                    skip_op = 1'b1;
                    skip = !io_val[bit_sel];
                end
                skip_io_bit_set: begin
                    skip_op = 1'b1;
                    skip = io_val[bit_sel];
                end
                no_operation: begin
                    next_st.pc_upd = 1'b0;
                end
                default: begin
                    next_st.taken = cond;
                    next_st.target = pc_add(pc, cond ? kofs : `PC_STEP);
                    next_st.cnt = cond ? `BR_T_CYC : `BR_NT_CYC;
                end
            endcase
            if (skip_op) begin
                // Skipping a two-word instruction costs one more cycle
                next_st.taken = skip;
                if (!skip) begin
                    next_st.target = pc_add(pc, `PC_STEP);
                    next_st.cnt = `SKIP_NT_CYC;
                end else if (next_two_word) begin
                    next_st.target = pc_add(pc, `PC_SKIP_TWO);
                    next_st.cnt = `SKIP_TWO_CYC;
                end else begin
                    next_st.target = pc_add(pc, `PC_SKIP_ONE);
                    next_st.cnt = `SKIP_ONE_CYC;
                end
            end
            // Counts include the accepting edge, so done stands in cycle N
            if (next_st.cnt != 3'h0) begin
                next_st.done = (next_st.cnt == 3'h1);
                next_st.cnt = next_st.cnt - 3'h1;
            end
        end
        // Extension register write lands for the next accepted instruction
        if (bus_wr && (bus_addr == `OFS_JEXT)) begin
            next_st.jump_ext = bus_wdata;
        end
        if (bus_rd) begin
            case (bus_addr)
                `OFS_JEXT: next_st.rdata = st.jump_ext;
                `OFS_STAT: begin
                    next_st.rdata[`STAT_BUSY] = (st.cnt != 3'h0);
                    next_st.rdata[`STAT_TAKEN] = st.taken;
                    next_st.rdata[`STAT_MUL] = st.is_mul;
                end
                `OFS_PROD_LO: next_st.rdata = st.prod[7:0];
                `OFS_PROD_HI: next_st.rdata = st.prod[15:8];
                default: next_st.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st <= ST_RST;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign ready = (st.cnt == 3'h0);
    assign done = st.done;
    assign pc_load = st.done && st.pc_upd;
    assign pc_value = st.target;
    assign prod_we = st.done && st.is_mul;
    assign prod_value = st.prod;
    assign flag_we = {8{st.done}} & st.fmask;
    assign flag_value = st.fval;
    assign ret_push = st.push;
    assign ret_addr = st.ret;
    assign bus_rdata = st.rdata;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    logic signed [15:0] smul_ref;
    logic [15:0] umul_ref;
    logic [PC_W-1:0] zext_ref;
    assign smul_ref = $signed(rd_val) * $signed(src_val);
    assign umul_ref = rd_val * src_val;
    assign zext_ref = PC_W'(z_ptr);

    sequence call_taken;
        accept && (op == pointer_call || op == extended_pointer_call);
    endsequence
    sequence push_then_load;
        ##1 (ret_push && !pc_load) ##3 (pc_load && flag_we == 8'h00);
    endsequence

    chk_signed_product: assert property (accept && op == signed_multiply
        |-> ##2 (prod_we && prod_value == $past(smul_ref, 2)))
        else $error("signed product wrong or late");
    chk_frac_shift: assert property (accept && op == fractional_unsigned_multiply
        |-> ##2 (prod_we && prod_value == {$past(umul_ref[14:0], 2), 1'b0}))
        else $error("fractional product not shifted");
    chk_mul_carry: assert property (prod_we
        |-> flag_we[`FLAG_C] && flag_value[`FLAG_Z] == (prod_value == 16'h0000))
        else $error("multiply flags wrong");
    chk_jump_target: assert property (accept && op == pointer_jump
        |-> ##1 !done ##1 (done && pc_value == $past(zext_ref, 2) && flag_we == 8'h00))
        else $error("pointer jump target wrong");
    chk_ext_jump: assert property (accept && op == extended_pointer_jump
        |-> ##2 (pc_load && pc_value == PC_W'({$past(st.jump_ext, 2), $past(z_ptr, 2)})))
        else $error("extended jump target wrong");
    chk_call_order: assert property (call_taken |-> push_then_load)
        else $error("call push or load out of order");
    chk_skip_equal: assert property (accept && op == compare_skip_equal && rd_val == src_val
        && !next_two_word |-> ##2 (pc_load && pc_value == $past(pc, 2) + PC_W'(2)))
        else $error("equal skip wrong");
    chk_compare_flags: assert property (accept && op == compare_immediate
        |-> ##1 (flag_we[`FLAG_Z] && flag_value[`FLAG_Z] == ($past(rd_val) == $past(imm))))
        else $error("compare zero flag wrong");
    chk_branch_ge: assert property (accept && op == branch_greater_equal && !n_xor_v
        |-> ##2 (pc_load && pc_value == pc_add($past(pc, 2), $past(kofs, 2))))
        else $error("greater-equal branch not taken");
    chk_branch_lt: assert property (accept && op == branch_less_than && !n_xor_v
        |-> ##1 (pc_load && pc_value == $past(pc) + PC_W'(1)))
        else $error("less-than branch taken wrongly");
endmodule

// ===== core/product_unit.sv
module product_unit (
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire logic a_signed,
    input wire logic b_signed,
    input wire logic frac,
    output logic [15:0] product,
    output logic carry,
    output logic zero
);
    logic signed [17:0] full;
    logic [15:0] raw;

    // Nine-bit extension covers all three sign mixes with one multiplier
    assign full = $signed({a_signed & a[7], a}) * $signed({b_signed & b[7], b});
    assign raw = full[15:0];
    assign carry = raw[15];
    assign product = frac ? {raw[14:0], 1'b0} : raw;
    assign zero = (product == 16'h0000);
endmodule

// ===== tb/multiply_branch_skip_exec_tb.sv
`include "exec_cfg.svh"

module multiply_branch_skip_exec_tb import exec_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;

    logic clock = 0, rst = 1, start = 0, next_two_word = 0, bus_wr = 0, bus_rd = 0;
    op_e op = no_operation;
    logic [7:0] rd_val = 0, src_val = 0, imm = 0, io_val = 0, status_register = 0, bus_wdata = 0;
    logic [2:0] bit_sel = 0, flag_sel = 0;
    logic [6:0] offset = 0;
    logic [15:0] z_ptr = 0;
    logic [21:0] pc = 0;
    logic [3:0] bus_addr = 0;
    logic ready, done, pc_load, prod_we, ret_push;
    logic [21:0] pc_value, ret_addr;
    logic [15:0] prod_value, last_prod;
    logic [7:0] flag_we, flag_value, bus_rdata, ext_model;
    logic [31:0] seed = 32'h48;
    int errors = 0, samples_checked = 0;
    op_e mul_ops[5] = '{signed_multiply, signed_by_unsigned_multiply, fractional_unsigned_multiply,
                        fractional_signed_multiply, fractional_mixed_multiply};
    op_e skip_ops[5] = '{compare_skip_equal, skip_reg_bit_clear, skip_reg_bit_set, skip_io_bit_clear,
                         skip_io_bit_set};

    exec_unit #(.PC_W(22)) dut (.clock(clock), .rst(rst), .start(start), .op(op), .rd_val(rd_val),
        .src_val(src_val), .imm(imm), .bit_sel(bit_sel), .io_val(io_val), .flag_sel(flag_sel),
        .offset(offset), .z_ptr(z_ptr), .pc(pc), .status_register(status_register),
        .next_two_word(next_two_word), .ready(ready), .done(done), .pc_load(pc_load),
        .pc_value(pc_value), .prod_we(prod_we), .prod_value(prod_value), .flag_we(flag_we),
        .flag_value(flag_value), .ret_push(ret_push), .ret_addr(ret_addr), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata));

    always #2 clock = ~clock;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("unexpected value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic check_cyc(input int got, input int exp);
        samples_checked++;
        if (got != exp) begin
            errors++;
            $display("unexpected cycle count at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic final_report();
        $display("checked %0d, mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic bus_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clock);
        bus_wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic bus_check(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clock);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clock);
        bus_rd <= 1'b0;
        #1 check_val(bus_rdata, exp);
    endtask

    task automatic rand_in();
        logic [31:0] r;
        @(posedge clock);
        r = rnd();
        rd_val <= r[7:0];
        src_val <= r[15:8];
        imm <= r[23:16];
        bit_sel <= r[26:24];
        flag_sel <= r[29:27];
        next_two_word <= r[30];
        r = rnd();
        io_val <= r[7:0];
        status_register <= r[15:8];
        offset <= r[22:16];
        z_ptr <= r[31:16];
        r = rnd();
        pc <= r[21:0];
        #1;
    endtask

    task automatic set_ops(input logic [7:0] a, input logic [7:0] b);
        @(posedge clock);
        rd_val <= a;
        src_val <= b;
        imm <= b;
        #1;
    endtask

    // ****************************************
    // Reference model and instruction driver
    // ****************************************
    task automatic run_op(input op_e o, input bit hold);
        int n, cyc, a, b;
        logic [15:0] p;
        logic [7:0] r, fv, fw, sr;
        logic ld, pw, push, cond;
        logic [21:0] npc;
        cyc = 1; ld = 1; pw = 0; push = 0; fw = 0; fv = 0; p = 0; cond = 0;
        npc = pc + 22'h1;
        sr = status_register;
        case (o)
            signed_multiply, signed_by_unsigned_multiply, fractional_unsigned_multiply,
            fractional_signed_multiply, fractional_mixed_multiply: begin
                a = rd_val;
                b = src_val;
                if (o != fractional_unsigned_multiply && rd_val[7]) a -= 256;
                if ((o == signed_multiply || o == fractional_signed_multiply) && src_val[7]) b -= 256;
                p = 16'(a * b);
                fv[`FLAG_C] = p[15];
                if (o >= fractional_unsigned_multiply) p = p << 1;
                fv[`FLAG_Z] = (p == 16'h0000);
                fw = 8'h03; cyc = 2; ld = 0; pw = 1;
            end
            compare_immediate: begin
                r = rd_val - imm;
                fv[`FLAG_C] = (~rd_val[7] & imm[7]) | (imm[7] & r[7]) | (r[7] & ~rd_val[7]);
                fv[`FLAG_Z] = (r == 8'h00);
                fv[`FLAG_N] = r[7];
                fv[`FLAG_V] = (rd_val[7] & ~imm[7] & ~r[7]) | (~rd_val[7] & imm[7] & r[7]);
                fv[`FLAG_H] = (~rd_val[3] & imm[3]) | (imm[3] & r[3]) | (r[3] & ~rd_val[3]);
                fw = 8'h2F; ld = 0;
            end
            pointer_jump: begin cyc = 2; npc = 22'(z_ptr); end
            extended_pointer_jump: begin cyc = 2; npc = 22'({ext_model, z_ptr}); end
            pointer_call: begin cyc = 4; push = 1; npc = 22'(z_ptr); end
            extended_pointer_call: begin cyc = 4; push = 1; npc = 22'({ext_model, z_ptr}); end
            compare_skip_equal: cond = (rd_val == src_val);
            skip_reg_bit_clear: cond = !src_val[bit_sel];
            skip_reg_bit_set: cond = src_val[bit_sel];
            skip_io_bit_clear: cond = !io_val[bit_sel];
            skip_io_bit_set: cond = io_val[bit_sel];
            branch_flag_set: cond = sr[flag_sel];
            branch_flag_clear: cond = !sr[flag_sel];
            branch_greater_equal: cond = !(sr[`FLAG_N] ^ sr[`FLAG_V]);
            branch_less_than: cond = sr[`FLAG_N] ^ sr[`FLAG_V];
            branch_half_carry_set: cond = sr[`FLAG_H];
            branch_half_carry_clear: cond = !sr[`FLAG_H];
            branch_transfer_bit_set: cond = sr[`FLAG_T];
            branch_transfer_bit_clear: cond = !sr[`FLAG_T];
            branch_same_or_higher, branch_carry_clear: cond = !sr[`FLAG_C];
            branch_lower, branch_carry_set: cond = sr[`FLAG_C];
            branch_overflow_set: cond = sr[`FLAG_V];
            branch_overflow_clear: cond = !sr[`FLAG_V];
            default: ld = 0;
        endcase
        if (cond && o >= branch_flag_set) begin
            cyc = 2;
            npc = pc + 22'($signed(offset)) + 22'h1;
        end else if (cond) begin
            cyc = next_two_word ? 3 : 2;
            npc = pc + (next_two_word ? 22'h3 : 22'h2);
        end
        @(posedge clock);
        op <= o;
        start <= 1'b1;
        #1 check_val(ready, 1'b1);
        @(posedge clock);
        start <= hold;
        // Push and a one-cycle done both stand right after the accepting edge
        #1 check_val(ret_push, push);
        if (push) check_val(ret_addr, pc + 22'h1);
        n = 1;
        while (done !== 1'b1 && n < 8) begin
            @(posedge clock);
            start <= 1'b0;
            #1 n++;
        end
        check_cyc(n, cyc);
        check_val(pc_load, ld);
        if (ld) check_val(pc_value, npc);
        check_val(prod_we, pw);
        if (pw) check_val(prod_value, p);
        check_val(flag_we, fw);
        check_val(flag_value & fw, fv);
        if (pw) last_prod = p;
    endtask

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        ext_model = `JEXT_RST;
        last_prod = 0;
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        #1 check_val({ready, done, pc_load, prod_we, ret_push}, 5'h10);
        bus_check(`OFS_JEXT, `JEXT_RST);
        bus_check(`OFS_PROD_HI, 8'h00);
        $display("reset test done");

        for (int i = 0; i < 5; i++) begin
            for (int j = 0; j < 6; j++) begin
                rand_in();
                if (j == 0) set_ops(8'h80, 8'h80);
                if (j == 1) set_ops(8'h00, src_val);
                if (j == 2) set_ops(8'hFF, 8'h01);
                run_op(mul_ops[i], j == 3);
            end
        end
        bus_check(`OFS_PROD_LO, last_prod[7:0]);
        bus_check(`OFS_PROD_HI, last_prod[15:8]);
        bus_write(`OFS_STAT, 8'hFF);
        bus_check(`OFS_STAT, 8'(1 << `STAT_MUL));
        $display("multiply test done");

        for (int j = 0; j < 10; j++) begin
            rand_in();
            if (j < 2) set_ops(rd_val, rd_val);
            if (j == 2) set_ops(8'h80, 8'h01);
            if (j == 3) set_ops(8'h10, 8'h01);
            run_op(compare_immediate, 0);
        end
        $display("compare test done");

        bus_write(`OFS_JEXT, 8'h2A);
        ext_model = 8'h2A;
        bus_check(`OFS_JEXT, 8'h2A);
        bus_write(4'h9, 8'h55);
        bus_check(`OFS_JEXT, 8'h2A);
        bus_check(4'h9, 8'h00);
        for (int j = 0; j < 3; j++) begin
            rand_in();
            run_op(pointer_jump, 0);
            run_op(extended_pointer_jump, 0);
            run_op(pointer_call, j == 0);
            run_op(extended_pointer_call, j == 1);
        end
        $display("jump and call test done");

        for (int i = 0; i < 5; i++) begin
            for (int j = 0; j < 8; j++) begin
                rand_in();
                if (j[0]) set_ops(src_val, src_val);
                run_op(skip_ops[i], 0);
            end
        end
        $display("skip test done");

        for (int o = branch_flag_set; o <= branch_overflow_clear; o++) begin
            for (int j = 0; j < 8; j++) begin
                rand_in();
                run_op(op_e'(o), 0);
            end
        end
        $display("branch test done");
        final_report();
    end

    initial begin
        #100000;
        errors++;
        final_report();
    end
endmodule
